// ===== inc/pac_pkg.sv
// constants for the pulse accumulator control block
package pac_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [7:0] CTRL_OFFSET = 8'h20;
    localparam logic [7:0] FLAG_OFFSET = 8'h21;
    localparam logic [7:0] CNTH_OFFSET = 8'h22;
    localparam logic [7:0] CNTL_OFFSET = 8'h23;
    localparam logic [7:0] MASK_OFFSET = 8'h24;
    localparam logic [7:0] STAT_OFFSET = 8'h25;
    // control field positions
    localparam int EN_BIT = 6;
    localparam int MODE_BIT = 5;
    localparam int EDGE_BIT = 4;
    localparam int CLK_HI_BIT = 3;
    localparam int CLK_LO_BIT = 2;
    localparam int OVI_BIT = 1;
    localparam int PAI_BIT = 0;
    // flag positions
    localparam int OVF_BIT = 1;
    localparam int EDGF_BIT = 0;
    // reset values and count top value
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [1:0] FLAG_RESET = 2'h0;
    // gate clock ratio and clock select encodings
    localparam int GATE_DIV = 64;
    localparam logic [5:0] GATE_LAST = 6'(GATE_DIV - 1);
    localparam logic [1:0] CLK_PRESCALE = 2'h0;
    localparam logic [1:0] CLK_ACCUM = 2'h1;
    localparam logic [1:0] CLK_DIV256 = 2'h2;
    localparam logic [1:0] CLK_DIV65536 = 2'h3;
endpackage

// ===== src/pac_unit.sv
// pulse accumulator control, count, flags and timer clock selection
// Operation
// - control bit 6 enables accumulator, timer independent
// - input shared with channel seven pin
// - bit 5 picks event or gated mode
// - event mode: bit 4 picks active edge
// - gated, edge zero: count high, fall flags
// - gated, edge one: count low, rise flags
// - divide-by-64 comes from prescaler, timer enabled
// - bits 3:2 select main timer clock source
// - disabled accumulator forces prescaler timer clock
// - clock source switches right after write
// - bit 1 gates overflow interrupt request
// - bit 0 gates edge interrupt request
// - control register accessible at any time
// - 16-bit count, overflow flag on wrap
// - input synchronised before counting
`timescale 1ns/1ns
`default_nettype none
module pac_unit (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic channel_seven_pin,
    input wire logic main_timer_enable,
    input wire logic prescale_tick,
    output logic timer_count_tick,
    output logic accum_irq
);
    // every check below lives on the bus clock and sleeps through reset
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // control, count, flag, mask and read data registers
    logic [7:0] ctrl_reg;
    logic [15:0] count_reg;
    logic [1:0] flag_reg;
    logic [1:0] mask_reg;
    logic [7:0] rdata_reg;
    // pin synchroniser and previous level
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;
    // gate clock divider and timer clock dividers
    logic [5:0] gate_div_reg;
    logic [7:0] div256_reg;
    logic [15:0] div65536_reg;

    // decoded fields
    wire accum_enable = ctrl_reg[pac_pkg::EN_BIT];
    wire accum_mode_select = ctrl_reg[pac_pkg::MODE_BIT];
    wire accum_edge_select = ctrl_reg[pac_pkg::EDGE_BIT];
    wire [1:0] clk_sel = ctrl_reg[pac_pkg::CLK_HI_BIT:pac_pkg::CLK_LO_BIT];
    wire accum_overflow_irq_en = ctrl_reg[pac_pkg::OVI_BIT];
    wire accum_input_irq_en = ctrl_reg[pac_pkg::PAI_BIT];

    // address decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction
    wire wr_ctrl = wr_stb && hit(addr, pac_pkg::CTRL_OFFSET);
    wire wr_flag = wr_stb && hit(addr, pac_pkg::FLAG_OFFSET);
    wire wr_cnth = wr_stb && hit(addr, pac_pkg::CNTH_OFFSET);
    wire wr_cntl = wr_stb && hit(addr, pac_pkg::CNTL_OFFSET);
    wire wr_mask = wr_stb && hit(addr, pac_pkg::MASK_OFFSET);

    // edges on the synchronised pin only
    wire pin_rise = pin_sync_reg && !pin_prev_reg;
    wire pin_fall = !pin_sync_reg && pin_prev_reg;

    // divide-by-64 tick exists only while the timer prescaler runs
    wire gate_tick = main_timer_enable && prescale_tick &&
        (gate_div_reg == pac_pkg::GATE_LAST);
    // gate open at pin high (edge 0) or pin low (edge 1)
    wire gate_open = accum_edge_select ? !pin_sync_reg : pin_sync_reg;
    // selected event edge in event mode
    wire event_edge = accum_edge_select ? pin_rise : pin_fall;
    // trailing edge of the gate in gated mode
    wire trail_edge = accum_edge_select ? pin_rise : pin_fall;

    // the accumulator clock: one pulse per count step
    wire accum_clock = accum_enable && (accum_mode_select ?
        (gate_tick && gate_open) : event_edge);
    // the edge flag source
    wire edge_event = accum_enable && (accum_mode_select ? trail_edge
        : event_edge);
    wire wrap = accum_clock && (count_reg == pac_pkg::COUNT_MAX);
    // flag clear only honoured while timer or accumulator runs
    wire clear_ok = main_timer_enable || accum_enable;
    wire [1:0] flag_clr = (wr_flag && clear_ok) ? wdata[1:0] : 2'h0;
    wire [1:0] flag_set = {wrap, edge_event};
    wire [1:0] flag_next = (flag_reg & ~flag_clr) | flag_set;

    // divided accumulator clocks for the timer counter
    wire tick_div256 = accum_clock && (div256_reg == 8'hff);
    wire tick_div65536 = accum_clock && (div65536_reg == 16'hffff);

    // combinational mux, so a select write takes effect at once
    logic sel_tick;
    always_comb begin
        case (clk_sel)
            pac_pkg::CLK_PRESCALE: sel_tick = prescale_tick;
            pac_pkg::CLK_ACCUM: sel_tick = accum_clock;
            pac_pkg::CLK_DIV256: sel_tick = tick_div256;
            pac_pkg::CLK_DIV65536: sel_tick = tick_div65536;
            default: sel_tick = prescale_tick;
        endcase
    end
    // disabled accumulator always hands over the prescaler
    assign timer_count_tick = accum_enable ? sel_tick
        : prescale_tick;

    // interrupt: sticky flags gated by control enables and mask
    wire [1:0] irq_en = {accum_overflow_irq_en, accum_input_irq_en};
    assign accum_irq = |(flag_reg & irq_en & mask_reg);

    // read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (addr)
            pac_pkg::CTRL_OFFSET: rd_mux = ctrl_reg;
            pac_pkg::FLAG_OFFSET: rd_mux = {6'h00, flag_reg};
            pac_pkg::CNTH_OFFSET: rd_mux = count_reg[15:8];
            pac_pkg::CNTL_OFFSET: rd_mux = count_reg[7:0];
            pac_pkg::MASK_OFFSET: rd_mux = {6'h00, mask_reg};
            pac_pkg::STAT_OFFSET: rd_mux = {6'h00, flag_reg & mask_reg};
            default: rd_mux = 8'h00;
        endcase
    end
    assign rdata = rdata_reg;

    // two-flop synchroniser on the shared pin
    // resets to the idle high level, so no false edge follows reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
            pin_prev_reg <= 1'b1;
        end else begin
            pin_meta_reg <= channel_seven_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // control register, writable any time
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= pac_pkg::CTRL_RESET;
            mask_reg <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= {1'b0, wdata[6:0]};
            end
            if (wr_mask) begin
                mask_reg <= wdata[1:0];
            end
        end
    end

    // prescaler-driven gate divider; frozen while the timer is off
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gate_div_reg <= 6'h00;
        end else if (main_timer_enable && prescale_tick) begin
            gate_div_reg <= gate_div_reg + 6'h01;
        end
    end

    // count; software write wins, hold while disabled
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= pac_pkg::COUNT_RESET;
        end else if (wr_cnth) begin
            count_reg <= {wdata, count_reg[7:0]};
        end else if (wr_cntl) begin
            count_reg <= {count_reg[15:8], wdata};
        end else if (accum_clock) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // timer clock prescalers on the accumulator clock
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div256_reg <= 8'h00;
            div65536_reg <= 16'h0000;
        end else if (accum_clock) begin
            div256_reg <= div256_reg + 8'h01;
            div65536_reg <= div65536_reg + 16'h0001;
        end
    end

    // sticky flags: set beats clear in the same cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flag_reg <= pac_pkg::FLAG_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rd_stb ? rd_mux : 8'h00;
        end
    end

    // helper: timer stopped, so no divide-by-64 tick can exist
    sequence s_timer_off;
        !main_timer_enable;
    endsequence
    // gated mode with the gate open and one divide-by-64 tick
    sequence s_gated_tick;
        accum_enable && accum_mode_select && gate_open && gate_tick;
    endsequence
    // software leaves both count bytes alone this cycle
    sequence s_no_count_write;
        !wr_cnth && !wr_cntl;
    endsequence

    // a stopped timer starves gated accumulation
    a_gated_needs_timer: assert property (
        s_timer_off |-> !(accum_mode_select && accum_clock))
        else $error("gated count advanced with timer off");
    // count frozen while the accumulator is off
    a_count_hold_off: assert property (
        (!accum_enable && !wr_cnth && !wr_cntl) |=> $stable(count_reg))
        else $error("count moved while disabled");
    // wrap from the top value lands on zero with overflow set
    a_wrap_sets_ovf: assert property (
        (s_no_count_write ##0 wrap)
        |=> flag_reg[pac_pkg::OVF_BIT] && count_reg == 16'h0000)
        else $error("wrap did not set overflow");
    // event mode, rising edge selected: one step per edge
    a_event_rise: assert property (
        (accum_enable && !accum_mode_select && accum_edge_select && pin_rise
         && !wr_cnth && !wr_cntl) |=> count_reg == $past(count_reg) + 16'h1)
        else $error("rising edge not counted");
    // a pin fall reaches the count three edges later
    a_pin_to_count: assert property (
        (accum_enable && !accum_mode_select && !accum_edge_select &&
         $past(channel_seven_pin, 3) && !$past(channel_seven_pin, 2))
        |-> accum_clock)
        else $error("falling edge missed after sync");
    // gated, edge zero: trailing fall sets the edge flag
    a_trail_flag: assert property (
        (accum_enable && accum_mode_select && !accum_edge_select && pin_fall)
        |=> flag_reg[pac_pkg::EDGF_BIT])
        else $error("trailing edge flag not set");
    // gated, edge one: a high pin keeps the gate shut
    a_gate_low_open: assert property (
        (accum_enable && accum_mode_select && accum_edge_select &&
         pin_sync_reg) |-> !accum_clock)
        else $error("gate counted at high level");
    // disabled accumulator always hands the prescaler on
    a_sel_disabled: assert property (
        !accum_enable |-> timer_count_tick == prescale_tick)
        else $error("disabled accumulator changed timer clock");
    // select one: the accumulator clock drives the timer
    a_sel_accum: assert property (
        (accum_enable && clk_sel == pac_pkg::CLK_ACCUM)
        |-> timer_count_tick == accum_clock)
        else $error("accumulator clock not selected");
    // a select write takes hold on the very next cycle
    a_sel_immediate: assert property (
        (wr_ctrl && wdata[6] && wdata[3:2] == pac_pkg::CLK_DIV256)
        |=> timer_count_tick == tick_div256)
        else $error("clock select slow to switch");
    // overflow flag with its enables raises the request
    a_irq_ovf: assert property (
        (flag_reg[pac_pkg::OVF_BIT] && accum_overflow_irq_en &&
         mask_reg[pac_pkg::OVF_BIT]) |-> accum_irq)
        else $error("overflow interrupt missing");
    // both control enables low: no request at all
    a_irq_off: assert property (
        (!accum_overflow_irq_en && !accum_input_irq_en) |-> !accum_irq)
        else $error("inhibited interrupt raised");
    // control writes land whatever the mode or enable
    a_ctrl_write: assert property (
        wr_ctrl |=> ctrl_reg == {1'b0, $past(wdata[6:0])})
        else $error("control write lost");
    // clears refused while timer and accumulator are both off
    a_clear_blocked: assert property (
        (wr_flag && !clear_ok && flag_reg[0]) |=> flag_reg[0])
        else $error("flag cleared while all disabled");
    // gated mode: every open tick is one count step
    a_gated_step: assert property (
        (s_gated_tick ##0 s_no_count_write)
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("gated tick not counted");
    // select zero with the accumulator on: prescaler drives
    a_sel_prescale: assert property (
        (accum_enable && clk_sel == pac_pkg::CLK_PRESCALE)
        |-> timer_count_tick == prescale_tick)
        else $error("prescaler clock not selected");
    // select two: accumulator clock over 256
    a_sel_div256: assert property (
        (accum_enable && clk_sel == pac_pkg::CLK_DIV256)
        |-> timer_count_tick == tick_div256)
        else $error("divide by 256 clock not selected");
    // select three: accumulator clock over 65536
    a_sel_div65536: assert property (
        (accum_enable && clk_sel == pac_pkg::CLK_DIV65536)
        |-> timer_count_tick == tick_div65536)
        else $error("divide by 65536 clock not selected");
    // edge flag with its enables raises the request
    a_irq_edge: assert property (
        (flag_reg[pac_pkg::EDGF_BIT] && accum_input_irq_en &&
         mask_reg[pac_pkg::EDGF_BIT]) |-> accum_irq)
        else $error("edge interrupt missing");
    // overflow enable low and no edge flag: request stays low
    a_ovf_inhibit: assert property (
        (!accum_overflow_irq_en && !flag_reg[pac_pkg::EDGF_BIT])
        |-> !accum_irq)
        else $error("overflow request not inhibited");
    // event mode: the chosen edge sets the edge flag
    a_event_flag: assert property (
        (accum_enable && !accum_mode_select && event_edge)
        |=> flag_reg[pac_pkg::EDGF_BIT])
        else $error("event edge flag not set");
    // gated mode counts only on a divide-by-64 tick
    a_gated_no_edge: assert property (
        (accum_enable && accum_mode_select && !gate_tick) |-> !accum_clock)
        else $error("gated mode counted a pin edge");
    // edge detector compares against the previous synced level
    a_prev_follows: assert property (
        pin_prev_reg == $past(pin_sync_reg))
        else $error("edge history flop out of step");
    // read data are zero outside the cycle after a read strobe
    a_rdata_idle: assert property (
        !$past(rd_stb) |-> rdata == 8'h00)
        else $error("read data outside their cycle");
    // the control enable bit alone starts the accumulator
    a_enable_bit: assert property (
        (wr_ctrl && wdata[pac_pkg::EN_BIT]) |=> accum_enable)
        else $error("enable bit write ignored");
endmodule
`default_nettype wire

// ===== tb/pac_pulse_src.sv
// pulse and gate source model for the shared channel seven pin
`timescale 1ns/1ns
`default_nettype none
module pac_pulse_src (
    input wire logic mclk,
    output var logic pin
);
    initial pin = 1'b1; // idles high between pulses
    // low-going pulses; random widths keep both levels past the synchroniser
    task automatic pulses(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (3 + $urandom_range(3)) @(posedge mclk);
            pin <= 1'b0;
            repeat (3 + $urandom_range(3)) @(posedge mclk);
            pin <= 1'b1;
        end
        repeat (6) @(posedge mclk); // let the last edge land in the count
    endtask
    // hold the gate at one level
    task automatic level(input logic v);
        @(posedge mclk);
        pin <= v;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the pulse accumulator control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    logic mclk = 1'b0, rstn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, v;
    logic pin, main_timer_enable = 1'b0, prescale_tick = 1'b0;
    logic tick_on = 1'b0, timer_count_tick, accum_irq;
    logic [15:0] c, c0;
    int n_mismatch = 0, compares = 0, n, n_pre = 0, n_tc = 0, p0, t0;
    logic [7:0] sels [3] = '{8'h04, 8'h40, 8'h44};
    always #25 mclk = ~mclk; // 20 mhz
    // prescaler stand-in: a pulse every other cycle while running
    always @(posedge mclk) prescale_tick <= tick_on & ~prescale_tick;
    // running totals of prescaler and timer counter steps
    always @(posedge mclk) begin
        n_pre <= n_pre + int'(prescale_tick);
        n_tc <= n_tc + int'(timer_count_tick);
    end
    pac_pulse_src src_u (.mclk(mclk), .pin(pin));
    pac_unit dut_u (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .channel_seven_pin(pin), .main_timer_enable(main_timer_enable),
        .prescale_tick(prescale_tick), .timer_count_tick(timer_count_tick),
        .accum_irq(accum_irq));
    // bit 7 of control is not implemented and reads zero
    function automatic logic [7:0] exp_ctrl(input logic [7:0] x);
        return x & 8'h7f;
    endfunction
    // timer steps: pin edges only when enabled with the accumulator clock
    function automatic int exp_tc(input logic [7:0] ct, input int e, pr);
        return (ct[6] && ct[3:2] == 2'h1) ? e : pr;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge mclk);
        addr <= a;
        wdata <= x;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        #1; // let the register update settle
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 q = rdata; // data stand only in this cycle
    endtask
    task automatic rdc(output logic [15:0] q);
        logic [7:0] h, l;
        rd(pac_pkg::CNTH_OFFSET, h);
        rd(pac_pkg::CNTL_OFFSET, l);
        q = {h, l};
    endtask
    task automatic end_sim;
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // hang guard, far beyond the few thousand cycles the tests need
    initial begin
        #2000000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h0807));
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        rd(pac_pkg::CTRL_OFFSET, d); `CHK(d, pac_pkg::CTRL_RESET)
        rdc(c); `CHK(c, pac_pkg::COUNT_RESET)
        rd(8'h30, d); `CHK(d, 8'h00)
        repeat (4) begin
            v = 8'($urandom);
            wr(pac_pkg::CTRL_OFFSET, v);
            rd(pac_pkg::CTRL_OFFSET, d); `CHK(d, exp_ctrl(v))
        end
        // event counting with the timer off, falling then rising edges
        n = 1 + $urandom_range(4);
        wr(pac_pkg::CTRL_OFFSET, 8'h40);
        wr(pac_pkg::CNTH_OFFSET, 8'h00);
        wr(pac_pkg::CNTL_OFFSET, 8'h00);
        src_u.pulses(n);
        rdc(c); `CHK(c, 16'(n))
        wr(pac_pkg::CTRL_OFFSET, 8'h50);
        src_u.pulses(n);
        rdc(c); `CHK(c, 16'(2 * n))
        // disabled: count holds, flag clear refused, irq still gated
        wr(pac_pkg::CTRL_OFFSET, 8'h00);
        src_u.pulses(3);
        rdc(c); `CHK(c, 16'(2 * n))
        wr(pac_pkg::FLAG_OFFSET, 8'h03);
        rd(pac_pkg::FLAG_OFFSET, d); `CHK(d, 8'h01)
        wr(pac_pkg::MASK_OFFSET, 8'h03);
        wr(pac_pkg::CTRL_OFFSET, 8'h01); `CHK(accum_irq, 1'b1)
        wr(pac_pkg::MASK_OFFSET, 8'h00); `CHK(accum_irq, 1'b0)
        wr(pac_pkg::MASK_OFFSET, 8'h03);
        wr(pac_pkg::CTRL_OFFSET, 8'h40); `CHK(accum_irq, 1'b0)
        wr(pac_pkg::CTRL_OFFSET, 8'h41);
        src_u.pulses(1);
        rdc(c); `CHK(c, 16'(2 * n + 1))
        wr(pac_pkg::FLAG_OFFSET, 8'h01); `CHK(accum_irq, 1'b0)
        // wrap from the top value sets the overflow flag
        wr(pac_pkg::CNTH_OFFSET, 8'hff);
        wr(pac_pkg::CNTL_OFFSET, 8'hff);
        wr(pac_pkg::CTRL_OFFSET, 8'h42);
        src_u.pulses(1);
        rdc(c); `CHK(c, pac_pkg::COUNT_RESET)
        rd(pac_pkg::FLAG_OFFSET, d); `CHK(d, 8'h03)
        rd(pac_pkg::MASK_OFFSET, d); `CHK(d, 8'h03)
        rd(pac_pkg::STAT_OFFSET, d); `CHK(d, 8'h03)
        `CHK(accum_irq, 1'b1)
        wr(pac_pkg::CTRL_OFFSET, 8'h40); `CHK(accum_irq, 1'b0)
        wr(pac_pkg::FLAG_OFFSET, 8'h03);
        // timer clock source per select field and enable
        main_timer_enable <= 1'b1;
        tick_on <= 1'b1;
        foreach (sels[i]) begin
            wr(pac_pkg::CTRL_OFFSET, sels[i]);
            p0 = n_pre;
            t0 = n_tc;
            src_u.pulses(n);
            `CHK(n_tc - t0, exp_tc(sels[i], n, n_pre - p0))
        end
        // gated accumulation, high gate then low gate
        wr(pac_pkg::FLAG_OFFSET, 8'h03);
        wr(pac_pkg::CNTL_OFFSET, 8'h00);
        wr(pac_pkg::CTRL_OFFSET, 8'h60);
        repeat (256) @(posedge mclk);
        rdc(c); `CHK(c >= 16'h1 && c <= 16'h3, 1'b1)
        src_u.level(1'b0);
        repeat (10) @(posedge mclk);
        rd(pac_pkg::FLAG_OFFSET, d); `CHK(d, 8'h01)
        rdc(c0);
        repeat (256) @(posedge mclk);
        rdc(c); `CHK(c, c0)
        wr(pac_pkg::CTRL_OFFSET, 8'h70);
        repeat (256) @(posedge mclk);
        rdc(c); `CHK(c - c0 >= 16'h1 && c - c0 <= 16'h3, 1'b1)
        main_timer_enable <= 1'b0;
        repeat (4) @(posedge mclk);
        rdc(c0);
        repeat (256) @(posedge mclk);
        rdc(c); `CHK(c, c0)
        wr(pac_pkg::FLAG_OFFSET, 8'h03);
        src_u.level(1'b1);
        repeat (10) @(posedge mclk);
        rd(pac_pkg::FLAG_OFFSET, d); `CHK(d, 8'h01)
        end_sim();
    end
endmodule
`default_nettype wire
